// [rtl/sense_pkg.sv]
// constants shared by the sense data reporter
package sense_pkg;
  // command block
  localparam logic [7:0]  OPC_REQ_SENSE     = 8'h03;
  localparam int          CDB_LEN           = 6;
  localparam int          CDB_ALLOC_IDX     = 4;
  localparam int          CDB_UNIT_HI       = 7;
  localparam int          CDB_UNIT_LO       = 5;
  // sense record
  localparam logic [6:0]  ERR_CURRENT       = 7'h70;
  localparam logic [6:0]  ERR_DEFERRED      = 7'h71;
  localparam logic [7:0]  ADD_SENSE_LEN     = 8'h0A;
  localparam logic [7:0]  SENSE_LEN         = 8'h12;
  localparam logic [31:0] CMD_INFO_NONE     = 32'h0FFF_FFFF;
  // register byte addresses
  localparam logic [7:0]  ADDR_CTRL         = 8'h00;
  localparam logic [7:0]  ADDR_STATUS       = 8'h04;
  localparam logic [7:0]  ADDR_INFO         = 8'h08;
  localparam logic [7:0]  ADDR_CMD_INFO     = 8'h0C;
  localparam logic [7:0]  ADDR_KEYS         = 8'h10;
  localparam logic [7:0]  ADDR_KEY_SPEC     = 8'h14;
  // ctrl fields
  localparam int          CTRL_COMPOSE      = 0;
  localparam int          CTRL_DEFER        = 1;
  // status fields
  localparam int          ST_ALLEGIANCE     = 0;
  localparam int          ST_DEFER_PEND     = 1;
  localparam int          ST_SENDING        = 2;
  localparam int          ST_SENT_LO        = 8;
  // keys register fields
  localparam int          KEY_LO            = 0;
  localparam int          ASC_LO            = 8;
  localparam int          ASCQ_LO           = 16;
  localparam int          KEY_INFO_VALID    = 24;
  localparam int          KEY_LEN_MISMATCH  = 25;
  // key specific register fields
  localparam int          KS_FIELD_LO       = 0;
  localparam int          KS_BITPTR_LO      = 16;
  localparam int          KS_BP_VALID       = 19;
  localparam int          KS_CDB_OR_DATA    = 20;
  localparam int          KS_VALID          = 21;
  // reset values
  localparam logic [31:0] KEYS_RESET        = 32'h0000_0000;
  localparam logic [31:0] KEY_SPEC_RESET    = 32'h0000_0000;
  localparam logic [31:0] INFO_RESET        = 32'h0000_0000;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b001,
    ST_SEND   = 3'b010,
    ST_STATUS = 3'b100
  } phase_e;
endpackage : sense_pkg

// [rtl/scsi_sense_data_reporter.sv]
// sense data reporter: record capture, contingent allegiance and request sense return
//
// Decided for this implementation: register access over APB and the register addresses.
module scsi_sense_data_reporter (
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // error events from command execution
  input  wire logic        errEvent,
  input  wire logic        cacheWriteFail,
  input  wire logic        fatalError,
  // command block bytes
  input  wire logic        cdbValid,
  input  wire logic        cdbFirst,
  input  wire logic [7:0]  cdbByte,
  output logic             cdbReady,
  // data-in stream
  output logic             dinValid,
  output logic [7:0]       dinByte,
  output logic             dinLast,
  input  wire logic        dinReady,
  // command end
  output logic             statusValid,
  output logic             statusCheck
);

  // staged fields written by firmware
  logic [31:0] infoStage_reg;
  logic [31:0] cmdInfoStage_reg;
  logic [31:0] keysStage_reg;
  logic [31:0] keySpecStage_reg;
  // retained record
  logic        recInfoValid_reg;
  logic [6:0]  recCode_reg;
  logic        recLenMis_reg;
  logic [3:0]  recKey_reg;
  logic [31:0] recInfo_reg;
  logic [31:0] recCmdInfo_reg;
  logic [7:0]  recAsc_reg;
  logic [7:0]  recAscq_reg;
  logic        recKsv_reg;
  logic        recCd_reg;
  logic        recBpv_reg;
  logic [2:0]  recBitPtr_reg;
  logic [15:0] recField_reg;

  logic        allegiance_reg;
  logic        deferPend_reg;
  sense_pkg::phase_e phase_reg;
  logic [2:0]  cdbIdx_reg;
  logic [7:0]  cdbOpc_reg;
  logic [2:0]  cdbUnit_reg;
  logic [7:0]  sendLen_reg;
  logic [7:0]  sendIdx_reg;
  logic [7:0]  sentCount_reg;
  logic        fatalSeen_reg;
  logic        statusValid_reg;
  logic        statusCheck_reg;
  logic        dinValid_reg;
  logic [7:0]  dinByte_reg;
  logic        dinLast_reg;

  logic        apbWrite;
  logic        apbRead;
  logic        addrHit;
  logic        ctrlWrite;
  logic        compose;
  logic        deferSet;
  logic        cdbTake;
  logic        cdbDone;
  logic        reqSense;
  logic        dinTake;
  logic        sendDone;
  logic [7:0]  allocLen;
  logic [7:0]  nextIdx;
  logic        senseStart;
  logic [7:0]  sendLenClamp;

  assign apbWrite = psel && penable && pwrite;
  assign apbRead  = psel && penable && !pwrite;
  assign pready   = 1'b1;
  assign addrHit  = (paddr == sense_pkg::ADDR_CTRL) || (paddr == sense_pkg::ADDR_STATUS) ||
                    (paddr == sense_pkg::ADDR_INFO) || (paddr == sense_pkg::ADDR_CMD_INFO) ||
                    (paddr == sense_pkg::ADDR_KEYS) || (paddr == sense_pkg::ADDR_KEY_SPEC);
  assign pslverr  = psel && penable && !addrHit;
  assign ctrlWrite = apbWrite && (paddr == sense_pkg::ADDR_CTRL);

  // an error seen by hardware or reported by firmware composes the record
  assign compose  = errEvent || (ctrlWrite && pwdata[sense_pkg::CTRL_COMPOSE]);
  assign deferSet = cacheWriteFail || (ctrlWrite && pwdata[sense_pkg::CTRL_DEFER]);

  // staged registers
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      infoStage_reg    <= sense_pkg::INFO_RESET;
      cmdInfoStage_reg <= sense_pkg::CMD_INFO_NONE;
      keysStage_reg    <= sense_pkg::KEYS_RESET;
      keySpecStage_reg <= sense_pkg::KEY_SPEC_RESET;
    end else if (apbWrite) begin
      case (paddr)
        sense_pkg::ADDR_INFO:     infoStage_reg    <= pwdata;
        sense_pkg::ADDR_CMD_INFO: cmdInfoStage_reg <= pwdata;
        sense_pkg::ADDR_KEYS:     keysStage_reg    <= pwdata;
        sense_pkg::ADDR_KEY_SPEC: keySpecStage_reg <= pwdata;
        default: ;
      endcase
    end
  end

  // apb read data
  // loaded in the setup cycle so that it stands through the access cycle
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        sense_pkg::ADDR_STATUS: begin
          prdata <= 32'h0000_0000;
          prdata[sense_pkg::ST_ALLEGIANCE] <= allegiance_reg;
          prdata[sense_pkg::ST_DEFER_PEND] <= deferPend_reg;
          prdata[sense_pkg::ST_SENDING]    <= (phase_reg == sense_pkg::ST_SEND);
          prdata[sense_pkg::ST_SENT_LO +: 8] <= sentCount_reg;
        end
        sense_pkg::ADDR_INFO:     prdata <= infoStage_reg;
        sense_pkg::ADDR_CMD_INFO: prdata <= cmdInfoStage_reg;
        sense_pkg::ADDR_KEYS:     prdata <= keysStage_reg;
        sense_pkg::ADDR_KEY_SPEC: prdata <= keySpecStage_reg;
        default:                  prdata <= 32'h0000_0000;
      endcase
    end
  end

  // a failed cached write waits for the next composed record
  // a failure arriving on the compose cycle itself still marks that record deferred
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      deferPend_reg <= 1'b0;
    end else if (deferSet) begin
      deferPend_reg <= 1'b1;
    end else if (compose) begin
      deferPend_reg <= 1'b0;
    end
  end

  // retained record: captured on compose, emptied once delivered
  // an error on the delivery cycle keeps the new record instead of clearing it
  always_ff @(posedge sys_clk) begin
    if (!resetn || (sendDone && !compose)) begin
      recInfoValid_reg <= 1'b0;
      recCode_reg      <= sense_pkg::ERR_CURRENT;
      recLenMis_reg    <= 1'b0;
      recKey_reg       <= 4'h0;
      recInfo_reg      <= sense_pkg::INFO_RESET;
      recCmdInfo_reg   <= sense_pkg::CMD_INFO_NONE;
      recAsc_reg       <= 8'h00;
      recAscq_reg      <= 8'h00;
      recKsv_reg       <= 1'b0;
      recCd_reg        <= 1'b0;
      recBpv_reg       <= 1'b0;
      recBitPtr_reg    <= 3'h0;
      recField_reg     <= 16'h0000;
    end else if (compose) begin
      recInfoValid_reg <= keysStage_reg[sense_pkg::KEY_INFO_VALID];
      recCode_reg      <= (deferPend_reg || deferSet) ? sense_pkg::ERR_DEFERRED
                                                      : sense_pkg::ERR_CURRENT;
      recLenMis_reg    <= keysStage_reg[sense_pkg::KEY_LEN_MISMATCH];
      recKey_reg       <= keysStage_reg[sense_pkg::KEY_LO +: 4];
      recInfo_reg      <= infoStage_reg;
      recCmdInfo_reg   <= cmdInfoStage_reg;
      recAsc_reg       <= keysStage_reg[sense_pkg::ASC_LO +: 8];
      recAscq_reg      <= keysStage_reg[sense_pkg::ASCQ_LO +: 8];
      recKsv_reg       <= keySpecStage_reg[sense_pkg::KS_VALID];
      recCd_reg        <= keySpecStage_reg[sense_pkg::KS_CDB_OR_DATA];
      recBpv_reg       <= keySpecStage_reg[sense_pkg::KS_BP_VALID];
      recBitPtr_reg    <= keySpecStage_reg[sense_pkg::KS_BITPTR_LO +: 3];
      recField_reg     <= keySpecStage_reg[sense_pkg::KS_FIELD_LO +: 16];
    end
  end

  // contingent allegiance: a new error wins over the clear
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      allegiance_reg <= 1'b0;
    end else if (compose) begin
      allegiance_reg <= 1'b1;
    end else if (sendDone) begin
      allegiance_reg <= 1'b0;
    end
  end

  // extended record byte selector
  function automatic logic [7:0] senseByte(input logic [7:0] idx);
    begin
      case (idx)
        8'd0:    senseByte = {recInfoValid_reg, recCode_reg};
        8'd1:    senseByte = 8'h00;
        8'd2:    senseByte = {2'b00, recLenMis_reg, 1'b0, recKey_reg};
        8'd3:    senseByte = recInfo_reg[31:24];
        8'd4:    senseByte = recInfo_reg[23:16];
        8'd5:    senseByte = recInfo_reg[15:8];
        8'd6:    senseByte = recInfo_reg[7:0];
        8'd7:    senseByte = sense_pkg::ADD_SENSE_LEN;
        8'd8:    senseByte = recCmdInfo_reg[31:24];
        8'd9:    senseByte = recCmdInfo_reg[23:16];
        8'd10:   senseByte = recCmdInfo_reg[15:8];
        8'd11:   senseByte = recCmdInfo_reg[7:0];
        8'd12:   senseByte = recAsc_reg;
        8'd13:   senseByte = recAscq_reg;
        8'd14:   senseByte = 8'h00;
        8'd15:   senseByte = {recKsv_reg, recCd_reg, 2'b00, recBpv_reg, recBitPtr_reg};
        8'd16:   senseByte = recField_reg[15:8];
        8'd17:   senseByte = recField_reg[7:0];
        default: senseByte = 8'h00;
      endcase
    end
  endfunction : senseByte

  // command block intake
  // command bytes wait while a record streams or status is given
  assign cdbReady = (phase_reg == sense_pkg::ST_IDLE);
  assign cdbTake  = cdbValid && cdbReady;
  assign cdbDone  = cdbTake && (cdbFirst ? 1'b0 : (cdbIdx_reg == 3'(sense_pkg::CDB_LEN - 1)));
  assign allocLen = cdbByte;
  assign reqSense = (cdbOpc_reg == sense_pkg::OPC_REQ_SENSE) && (cdbUnit_reg == 3'b000);
  // a complete request sense block for unit 0 taken while idle starts the data-in phase
  assign senseStart = (phase_reg == sense_pkg::ST_IDLE) && cdbDone && reqSense;
  // a short allocation length ends the data-in phase early
  assign sendLenClamp = (allocLen < sense_pkg::SENSE_LEN) ? allocLen : sense_pkg::SENSE_LEN;

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      cdbIdx_reg  <= 3'h0;
      cdbOpc_reg  <= 8'h00;
      cdbUnit_reg <= 3'h0;
    end else if (cdbTake) begin
      if (cdbFirst) begin
        cdbIdx_reg <= 3'h1;
        cdbOpc_reg <= cdbByte;
      end else begin
        cdbIdx_reg <= cdbDone ? 3'h0 : cdbIdx_reg + 3'h1;
        if (cdbIdx_reg == 3'h1) begin
          cdbUnit_reg <= cdbByte[sense_pkg::CDB_UNIT_HI:sense_pkg::CDB_UNIT_LO];
        end
      end
    end
  end

  // data-in transfer
  assign dinTake  = dinValid_reg && dinReady;
  assign sendDone = (phase_reg == sense_pkg::ST_SEND) &&
                    ((sendLen_reg == 8'h00) || (dinTake && dinLast_reg));
  assign nextIdx  = sendIdx_reg + 8'h01;

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      phase_reg    <= sense_pkg::ST_IDLE;
      sendLen_reg  <= 8'h00;
      sendIdx_reg  <= 8'h00;
      dinValid_reg <= 1'b0;
      dinByte_reg  <= 8'h00;
      dinLast_reg  <= 1'b0;
    end else begin
      case (phase_reg)
        sense_pkg::ST_IDLE: begin
          // length byte is the last one needed; the sixth byte starts the send
          if (cdbTake && !cdbFirst && cdbIdx_reg == 3'(sense_pkg::CDB_ALLOC_IDX)) begin
            sendLen_reg <= sendLenClamp;
          end
          if (senseStart) begin
            phase_reg    <= sense_pkg::ST_SEND;
            sendIdx_reg  <= 8'h00;
            dinValid_reg <= (sendLen_reg != 8'h00);
            dinByte_reg  <= senseByte(8'h00);
            dinLast_reg  <= (sendLen_reg == 8'h01);
          end
        end
        sense_pkg::ST_SEND: begin
          // a zero allocation length ends the phase before any byte
          if (sendDone) begin
            phase_reg    <= sense_pkg::ST_STATUS;
            dinValid_reg <= 1'b0;
            dinLast_reg  <= 1'b0;
          end else if (dinTake) begin
            sendIdx_reg <= nextIdx;
            dinByte_reg <= senseByte(nextIdx);
            dinLast_reg <= (nextIdx + 8'h01 == sendLen_reg);
          end
        end
        sense_pkg::ST_STATUS: begin
          phase_reg <= sense_pkg::ST_IDLE;
        end
        default: phase_reg <= sense_pkg::ST_IDLE;
      endcase
    end
  end

  // count of bytes delivered by the last request sense
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      sentCount_reg <= 8'h00;
    end else if (senseStart) begin
      sentCount_reg <= 8'h00;
    end else if (dinTake) begin
      sentCount_reg <= sentCount_reg + 8'h01;
    end
  end

  // fatal error seen while request sense runs
  always_ff @(posedge sys_clk) begin
    if (!resetn || phase_reg == sense_pkg::ST_IDLE) begin
      fatalSeen_reg <= 1'b0;
    end else if (fatalError) begin
      fatalSeen_reg <= 1'b1;
    end
  end

  // status: check condition on error outside the ST_STATUS cycle, good after request sense unless fatal
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      statusValid_reg <= 1'b0;
      statusCheck_reg <= 1'b0;
    end else if (phase_reg == sense_pkg::ST_STATUS) begin
      statusValid_reg <= 1'b1;
      statusCheck_reg <= fatalSeen_reg || fatalError;
    end else if (compose) begin
      // firmware-reported errors end the command the same way as hardware ones
      statusValid_reg <= 1'b1;
      statusCheck_reg <= 1'b1;
    end else begin
      statusValid_reg <= 1'b0;
      statusCheck_reg <= 1'b0;
    end
  end

  assign dinValid    = dinValid_reg;
  assign dinByte     = dinByte_reg;
  assign dinLast     = dinLast_reg;
  assign statusValid = statusValid_reg;
  assign statusCheck = statusCheck_reg;

endmodule : scsi_sense_data_reporter

// [verif/sense_reporter_checker.sv]
// port assertions for the sense data reporter
module sense_reporter_checker (
  input wire logic       sys_clk,
  input wire logic       resetn,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic [7:0] paddr,
  input wire logic       pslverr,
  input wire logic       errEvent,
  input wire logic       cdbReady,
  input wire logic       dinValid,
  input wire logic [7:0] dinByte,
  input wire logic       dinLast,
  input wire logic       dinReady,
  input wire logic       statusValid,
  input wire logic       statusCheck
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [4:0] idx_reg;
  // index of the record byte on offer
  always_ff @(posedge sys_clk) begin
    if (!resetn || statusValid) begin
      idx_reg <= 5'h00;
    end else if (dinValid && dinReady) begin
      idx_reg <= idx_reg + 5'h01;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  a_err_check: assert property (
    errEvent && cdbReady && !statusValid && !$past(dinLast) |=> statusValid && statusCheck)
    else $error("error event without check status");
  a_din_hold: assert property (
    dinValid && !dinReady |=> dinValid && $stable(dinByte) && $stable(dinLast))
    else $error("data byte changed before taken");
  a_cdb_block: assert property (dinValid |-> !cdbReady)
    else $error("command bytes taken while sending");
  a_code_byte: assert property (
    dinValid && idx_reg == 5'h00 |-> dinByte[6:0] inside {7'h70, 7'h71})
    else $error("bad error code");
  a_len_byte: assert property (dinValid && idx_reg == 5'h07 |-> dinByte == 8'h0A)
    else $error("bad additional length");
  a_zero_bytes: assert property (
    dinValid && idx_reg inside {5'h01, 5'h0E} |-> dinByte == 8'h00)
    else $error("reserved byte not zero");
  a_max_count: assert property (dinValid |-> idx_reg < 5'h12 && (idx_reg != 5'h11 || dinLast))
    else $error("record longer than eighteen bytes");
  a_last_status: assert property (
    dinValid && dinReady && dinLast |-> ##[1:3] statusValid)
    else $error("no status after last byte");
  a_unmapped_err: assert property (psel && penable && paddr > 8'h14 |-> pslverr)
    else $error("unmapped access not refused");
  c_check: cover property (statusValid && statusCheck);
  c_last: cover property (dinValid && dinReady && dinLast);
  c_stall: cover property (dinValid && !dinReady);
endmodule : sense_reporter_checker

bind scsi_sense_data_reporter sense_reporter_checker i_sense_reporter_checker (
  .sys_clk, .resetn, .psel, .penable, .paddr, .pslverr, .errEvent, .cdbReady,
  .dinValid, .dinByte, .dinLast, .dinReady, .statusValid, .statusCheck
);

// [verif/scsi_initiator_model.sv]
// initiator model: sends a six byte command block and takes sense bytes
module scsi_initiator_model (
  input wire logic       sys_clk,
  input wire logic       resetn,
  input wire logic       start,
  input wire logic       slow,
  input wire logic [7:0] opcode,
  input wire logic [7:0] unitByte,
  input wire logic [7:0] alloc,
  input wire logic       cdbReady,
  input wire logic       dinValid,
  input wire logic [7:0] dinByte,
  output logic           cdbValid,
  output logic           cdbFirst,
  output logic [7:0]     cdbByte,
  output logic           dinReady,
  output logic [7:0]     rxCount,
  output logic [7:0]     rx [18]
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [2:0] idx;
  logic       tog;
  always @(posedge sys_clk) begin
    if (!resetn) begin
      cdbValid <= 1'b0;
      cdbFirst <= 1'b0;
      cdbByte <= 8'h00;
      idx <= 3'h0;
    end else if (start) begin
      cdbValid <= 1'b1;
      cdbFirst <= 1'b1;
      cdbByte <= opcode;
      idx <= 3'h0;
    end else if (cdbValid && cdbReady) begin
      idx <= idx + 3'h1;
      cdbFirst <= 1'b0;
      cdbValid <= idx != 3'h5;
      // idle byte lines show the inverse of the last byte
      cdbByte <= (idx == 3'h5) ? ~cdbByte : (idx == 3'h0) ? unitByte : (idx == 3'h3) ? alloc : 8'h00;
    end
  end
  // a slow initiator takes a byte every other cycle
  assign dinReady = !slow || tog;
  always @(posedge sys_clk) begin
    tog <= resetn && !tog;
    if (!resetn || start) begin
      rxCount <= 8'h00;
    end else if (dinValid && dinReady) begin
      rx[rxCount] <= dinByte;
      rxCount <= rxCount + 8'h01;
    end
  end
endmodule : scsi_initiator_model

// [verif/scsi_sense_data_reporter_tb.sv]
// self-checking bench for the sense data reporter
module scsi_sense_data_reporter_tb;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {
    logic [7:0]  alloc;
    logic [7:0]  cnt;
    logic        slow;
    logic [1:0]  how;
    logic [31:0] keys;
    logic [31:0] spec;
    logic [31:0] info;
    logic [31:0] cmd;
  } row_s;
  // how: 0 error event, 1 compose over the bus, 2 failed cached write first
  row_s rows [4] = '{
    '{8'h12, 8'h12, 1'b0, 2'h0, 32'h0100_1103, 32'h0000_0000, 32'h0012_3456, 32'h0FFF_FFFF},
    '{8'hFF, 8'h12, 1'b1, 2'h2, 32'h0200_2405, 32'h003D_0004, 32'h0000_0000, 32'h0000_0A10},
    '{8'h07, 8'h07, 1'b1, 2'h1, 32'h0300_0C01, 32'h0020_0102, 32'hDEAD_BEEF, 32'h0FFF_FFFF},
    '{8'h00, 8'h00, 1'b0, 2'h0, 32'h0000_0004, 32'h0000_0000, 32'h0000_0000, 32'h0FFF_FFFF}};
  logic        sys_clk, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, start = 1'b0, slow = 1'b0;
  logic        errEvent = 1'b0, cacheWriteFail = 1'b0, fatalError = 1'b0, lastCheck;
  logic        pready, pslverr, cdbValid, cdbFirst, cdbReady, dinValid, dinLast, dinReady, statusValid, statusCheck;
  logic [7:0]  paddr = 8'h00, opcode = 8'h00, unitByte = 8'h00, alloc = 8'h00, cdbByte, dinByte, rxCount;
  logic [7:0]  rx [18];
  logic [31:0] pwdata = 32'h0000_0000, prdata;
  int          nStatus = 0, err_total = 0, compares = 0;
  scsi_sense_data_reporter i_scsi_sense_data_reporter (
    .sys_clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .errEvent,
    .cacheWriteFail, .fatalError, .cdbValid, .cdbFirst, .cdbByte, .cdbReady, .dinValid, .dinByte, .dinLast,
    .dinReady, .statusValid, .statusCheck);
  scsi_initiator_model i_scsi_initiator_model (
    .sys_clk, .resetn, .start, .slow, .opcode, .unitByte, .alloc, .cdbReady, .dinValid, .dinByte,
    .cdbValid, .cdbFirst, .cdbByte, .dinReady, .rxCount, .rx);
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    if (statusValid === 1'b1) begin
      nStatus++;
      lastCheck = statusCheck;
    end
  end
  function automatic logic [7:0] recb(input int i, input logic df, input logic [31:0] k, s, f, c);
    logic [7:0] r [18];
    r = '{{k[24], df ? 7'h71 : 7'h70}, 8'h00, {2'b00, k[25], 1'b0, k[3:0]}, f[31:24], f[23:16], f[15:8], f[7:0],
          8'h0A, c[31:24], c[23:16], c[15:8], c[7:0], k[15:8], k[23:16], 8'h00,
          {s[21:20], 2'b00, s[19:16]}, s[15:8], s[7:0]};
    return r[i];
  endfunction : recb
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH at %0t: seen 0x%h expected 0x%h", $time, seen, exp);
    end
  endtask : chk
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_sim
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q, output logic e);
    int i;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge sys_clk);
      if (pready === 1'b1) break;
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
    if (i == 50) chk(32'h0000_0000, 32'h0000_0001);
    if (i == 50) end_sim();
  endtask : apb
  task automatic wait_status(input int n0);
    for (int i = 0; i < 300 && nStatus == n0; i++) @(posedge sys_clk);
    if (nStatus == n0) chk(32'h0000_0000, 32'h0000_0001);
    if (nStatus == n0) end_sim();
  endtask : wait_status
  task automatic issue(input logic [7:0] op, input logic [7:0] un, input logic [7:0] al, input logic sl);
    opcode <= op;
    unitByte <= un;
    alloc <= al;
    slow <= sl;
    start <= 1'b1;
    @(posedge sys_clk);
    start <= 1'b0;
  endtask : issue
  task automatic sense(input logic [7:0] al, input logic sl);
    int n0;
    n0 = nStatus;
    issue(8'h03, 8'h00, al, sl);
    wait_status(n0);
  endtask : sense
  task automatic raise(input logic viaBus);
    int n0;
    logic [31:0] q;
    logic e;
    n0 = nStatus;
    if (viaBus) apb(1'b1, sense_pkg::ADDR_CTRL, 32'h0000_0001, q, e);
    if (!viaBus) errEvent <= 1'b1;
    if (!viaBus) @(posedge sys_clk);
    errEvent <= 1'b0;
    wait_status(n0);
    chk(lastCheck, 1'b1);
  endtask : raise
  task automatic do_reset();
    resetn <= 1'b0;
    repeat (16) @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
  endtask : do_reset
  initial begin
    logic [31:0] q;
    logic e;
    int n0;
    do_reset();
    foreach (rows[r]) begin
      apb(1'b1, sense_pkg::ADDR_INFO, rows[r].info, q, e);
      apb(1'b1, sense_pkg::ADDR_CMD_INFO, rows[r].cmd, q, e);
      apb(1'b1, sense_pkg::ADDR_KEYS, rows[r].keys, q, e);
      apb(1'b1, sense_pkg::ADDR_KEY_SPEC, rows[r].spec, q, e);
      cacheWriteFail <= rows[r].how == 2'h2;
      @(posedge sys_clk);
      cacheWriteFail <= 1'b0;
      apb(1'b0, sense_pkg::ADDR_STATUS, 32'h0000_0000, q, e);
      chk(q[1], rows[r].how == 2'h2);
      raise(rows[r].how == 2'h1);
      apb(1'b0, sense_pkg::ADDR_STATUS, 32'h0000_0000, q, e);
      chk(q[0], 1'b1);
      sense(rows[r].alloc, rows[r].slow);
      chk(lastCheck, 1'b0);
      chk(rxCount, rows[r].cnt);
      for (int i = 0; i < rows[r].cnt; i++) begin
        q = recb(i, rows[r].how == 2'h2, rows[r].keys, rows[r].spec, rows[r].info, rows[r].cmd);
        if (i < 8) chk(rx[i], q);
        else chk(rx[i], q);
      end
      apb(1'b0, sense_pkg::ADDR_STATUS, 32'h0000_0000, q, e);
      chk(q[15:0], {rows[r].cnt, 8'h00});
      $display("row %0d done", r);
    end
    raise(1'b0);
    sense(8'h07, 1'b0);
    sense(8'h12, 1'b1);
    chk({rx[0], rx[2], rxCount}, 24'h7000_12);
    raise(1'b0);
    fatalError <= 1'b1;
    sense(8'h12, 1'b0);
    fatalError <= 1'b0;
    chk(lastCheck, 1'b1);
    $display("truncation and fatal tests done");
    for (int i = 0; i < 2; i++) begin
      n0 = nStatus;
      issue(i ? 8'h03 : 8'h12, i ? 8'h20 : 8'h00, 8'h12, 1'b0);
      repeat (30) @(posedge sys_clk);
      chk({nStatus[7:0], rxCount}, {n0[7:0], 8'h00});
    end
    apb(1'b0, 8'h40, 32'h0000_0000, q, e);
    chk({31'h0000_0000, e}, 32'h0000_0001);
    chk(q, 32'h0000_0000);
    $display("refusal tests done");
    do_reset();
    apb(1'b0, sense_pkg::ADDR_CMD_INFO, 32'h0000_0000, q, e);
    chk(q, sense_pkg::CMD_INFO_NONE);
    apb(1'b0, sense_pkg::ADDR_STATUS, 32'h0000_0000, q, e);
    chk(q, 32'h0000_0000);
    sense(8'h12, 1'b0);
    for (int i = 0; i < 18; i++) chk(rx[i], recb(i, 1'b0, 0, 0, 0, sense_pkg::CMD_INFO_NONE));
    $display("reset test done");
    end_sim();
  end
endmodule : scsi_sense_data_reporter_tb
